// *** common/sram_host_pkg.sv ***
package sram_host_pkg;
    // Geometry of one port
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    // Write strobe width: larger of pulse width or turn-off plus data set-up
    localparam int WRITE_PULSE_NS = 12;
    localparam int OUT_TO_HIZ_NS = 10;
    localparam int DATA_SETUP_NS = 10;
    localparam int WRITE_HOLD_AFTER_BUSY_NS = 12;
    localparam int SEM_WRITE_TO_READ_NS = 5;
    localparam int READ_ACCESS_NS = 15;
    localparam int RELEASE_TO_DATA_NS = 17;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_OE_CYC =
        (OUT_TO_HIZ_NS + DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WH_CYC =
        (WRITE_HOLD_AFTER_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWR_CYC =
        (SEM_WRITE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC =
        (READ_ACCESS_NS + RELEASE_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    // Controller sequence states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_WSTROBE = 7'h04,
        ST_WHOLD = 7'h08,
        ST_RACCESS = 7'h10,
        ST_GAP = 7'h20,
        ST_DONE = 7'h40
    } state_e;
endpackage

// *** design/cycle_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// Down counter that pulses when a loaded count expires
module cycle_timer (
    input wire logic clk_sys_i, // System clock
    input wire logic nrst_i, // Async reset, low
    input wire logic load_i, // Load count
    input wire logic [sram_host_pkg::CNT_W-1:0] count_i, // Cycles to wait
    output logic expired_o // Count at one and no load this cycle
);
    logic [sram_host_pkg::CNT_W-1:0] cnt_reg;
    logic [sram_host_pkg::CNT_W-1:0] cnt_next;

    // Next count
    always_comb
    begin
        cnt_next = cnt_reg;
        if (load_i)
        begin
            cnt_next = count_i;
        end
        else if (cnt_reg != sram_host_pkg::CNT_ZERO)
        begin
            cnt_next = cnt_reg - sram_host_pkg::CNT_ONE;
        end
    end

    // Count register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= sram_host_pkg::CNT_ZERO;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired_o = (cnt_reg == sram_host_pkg::CNT_ONE) && !load_i;
endmodule
`default_nettype wire

// *** design/sram_port_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Address changes only with strobes inactive
// - No write data while device drives
// - Stretch strobe when output enable low
// - Array or semaphore select held valid
// - Chip select high across semaphore write-read
module sram_port_host (
    input wire logic clk_sys_i, // System clock
    input wire logic nrst_i, // Async reset, low
    input wire logic req_valid_i, // Request present
    output logic req_ready_o, // Request taken
    input wire logic req_write_i, // 1 write, 0 read
    input wire logic req_sem_i, // 1 semaphore, 0 array
    input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr_i, // Word address
    input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata_i, // Write data
    input wire logic [1:0] req_byte_en_i, // Byte lanes, bit1 upper
    output logic rsp_valid_o, // Completion pulse
    output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_o, // Read data
    output logic rsp_sem_flag_o, // Semaphore state read
    output logic rsp_sem_mismatch_o, // Semaphore pins disagreed
    output logic [sram_host_pkg::ADDR_W-1:0] addr_o, // Address pins
    output logic chip_sel_n_o, // Chip select, low
    output logic rd_wr_n_o, // Read high, write low
    output logic out_en_n_o, // Output enable, low
    output logic upper_byte_en_n_o, // Upper byte enable, low
    output logic lower_byte_en_n_o, // Lower byte enable, low
    output logic flag_select_n_o, // Semaphore select, low
    input wire logic [sram_host_pkg::DATA_W-1:0] data_i, // Data pins in
    output logic [sram_host_pkg::DATA_W-1:0] data_o, // Data pins out
    output logic data_oe_o, // Data pins driven
    input wire logic busy_n_i, // Contention flag pin, low
    input wire logic master_mode_i // Device strapped as master
);
    sram_host_pkg::state_e st_reg, st_next;
    logic [sram_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [sram_host_pkg::DATA_W-1:0] wdata_reg, wdata_next;
    logic [sram_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0] be_reg, be_next;
    logic wr_reg, wr_next, sem_reg, sem_next;
    logic prev_sem_wr_reg, prev_sem_wr_next;
    logic flag_reg, flag_next, mism_reg, mism_next;
    logic load;
    logic [sram_host_pkg::CNT_W-1:0] load_cnt;
    logic expired;
    logic busy;

    assign busy = !busy_n_i;

    cycle_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .load_i(load),
        .count_i(load_cnt),
        .expired_o(expired)
    );

    assign req_ready_o = (st_reg == sram_host_pkg::ST_IDLE);

    // Sequencer next state
    always_comb
    begin
        st_next = st_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        be_next = be_reg;
        wr_next = wr_reg;
        sem_next = sem_reg;
        prev_sem_wr_next = prev_sem_wr_reg;
        flag_next = flag_reg;
        mism_next = mism_reg;
        load = 1'b0;
        load_cnt = sram_host_pkg::CNT_ZERO;
        case (st_reg)
            sram_host_pkg::ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    addr_next = req_addr_i;
                    wdata_next = req_wdata_i;
                    be_next = req_byte_en_i;
                    wr_next = req_write_i;
                    sem_next = req_sem_i;
                    st_next = sram_host_pkg::ST_SETUP;
                end
            end
            sram_host_pkg::ST_SETUP:
            begin
                load = 1'b1;
                if (wr_reg)
                begin
                    load_cnt = 4'(sram_host_pkg::WP_OE_CYC > sram_host_pkg::WP_CYC ?
                        sram_host_pkg::WP_OE_CYC : sram_host_pkg::WP_CYC);
                    st_next = sram_host_pkg::ST_WSTROBE;
                end
                else
                begin
                    if (sem_reg && prev_sem_wr_reg)
                    begin
                        load_cnt = 4'(sram_host_pkg::RD_CYC + sram_host_pkg::SWR_CYC);
                    end
                    else
                    begin
                        load_cnt = 4'(sram_host_pkg::RD_CYC);
                    end
                    st_next = sram_host_pkg::ST_RACCESS;
                end
            end
            sram_host_pkg::ST_WSTROBE:
            begin
                if (!master_mode_i && busy)
                begin
                    load = 1'b1;
                    load_cnt = 4'(sram_host_pkg::WH_CYC);
                    st_next = sram_host_pkg::ST_WHOLD;
                end
                else if (expired)
                begin
                    prev_sem_wr_next = sem_reg;
                    st_next = sram_host_pkg::ST_GAP;
                end
            end
            sram_host_pkg::ST_WHOLD:
            begin
                if (busy)
                begin
                    load = 1'b1;
                    load_cnt = 4'(sram_host_pkg::WH_CYC);
                end
                else if (expired)
                begin
                    prev_sem_wr_next = sem_reg;
                    st_next = sram_host_pkg::ST_GAP;
                end
            end
            sram_host_pkg::ST_RACCESS:
            begin
                if (master_mode_i && busy)
                begin
                    load = 1'b1;
                    load_cnt = 4'(sram_host_pkg::RD_CYC);
                end
                else if (expired)
                begin
                    rdata_next = data_i;
                    flag_next = data_i[0];
                    mism_next = sem_reg && (data_i != {sram_host_pkg::DATA_W{data_i[0]}});
                    prev_sem_wr_next = 1'b0;
                    st_next = sram_host_pkg::ST_GAP;
                end
            end
            sram_host_pkg::ST_GAP:
            begin
                st_next = sram_host_pkg::ST_DONE;
            end
            sram_host_pkg::ST_DONE:
            begin
                st_next = sram_host_pkg::ST_IDLE;
            end
            default:
            begin
                st_next = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_reg <= sram_host_pkg::ST_IDLE;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            be_reg <= 2'h0;
            wr_reg <= 1'b0;
            sem_reg <= 1'b0;
            prev_sem_wr_reg <= 1'b0;
            flag_reg <= 1'b0;
            mism_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            be_reg <= be_next;
            wr_reg <= wr_next;
            sem_reg <= sem_next;
            prev_sem_wr_reg <= prev_sem_wr_next;
            flag_reg <= flag_next;
            mism_reg <= mism_next;
        end
    end

    logic active, strobe;
    assign active = (st_reg == sram_host_pkg::ST_WSTROBE) ||
        (st_reg == sram_host_pkg::ST_WHOLD) || (st_reg == sram_host_pkg::ST_RACCESS);
    assign strobe = (st_reg == sram_host_pkg::ST_WSTROBE) || (st_reg == sram_host_pkg::ST_WHOLD);

    // Pin drive
    always_comb
    begin
        addr_o = addr_reg;
        // one select of the pair low
        chip_sel_n_o = !(active && !sem_reg);
        flag_select_n_o = !(active && sem_reg);
        // write falls with select, outputs off
        rd_wr_n_o = !strobe;
        out_en_n_o = !(st_reg == sram_host_pkg::ST_RACCESS);
        // semaphore access keeps byte enables high
        upper_byte_en_n_o = !(active && !sem_reg && be_reg[1]);
        lower_byte_en_n_o = !(active && !sem_reg && be_reg[0]);
        // drive data only during write strobe
        data_o = wdata_reg;
        data_oe_o = strobe;
    end

    assign rsp_valid_o = (st_reg == sram_host_pkg::ST_DONE);
    assign rsp_rdata_o = rdata_reg;
    assign rsp_sem_flag_o = flag_reg;
    assign rsp_sem_mismatch_o = mism_reg;
endmodule
`default_nettype wire

// *** tb/dual_port_ram_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behavioural far-side memory with flags
module dual_port_ram_model (
    input wire logic clk_sys_i, // Clock
    input wire logic [14:0] addr_i, // Address
    input wire logic chip_sel_n_i, // Select
    input wire logic rd_wr_n_i, // Direction
    input wire logic out_en_n_i, // Output enable
    input wire logic upper_byte_en_n_i, // Upper lane
    input wire logic lower_byte_en_n_i, // Lower lane
    input wire logic flag_select_n_i, // Flag select
    input wire logic [15:0] bus_i, // Resolved data
    input wire logic master_mode_i, // Mode
    input wire logic far_sel_i, // Other port selected
    input wire logic [14:0] far_addr_i, // Other port address
    input wire logic far_busy_n_i, // Slave flag in
    output logic [15:0] rdata_o, // Driven data
    output logic busy_n_o // Contention flag
);
    logic [15:0] mem [int];
    logic [7:0] flags = 8'hff;
    logic [15:0] last = 16'h0000;
    logic [15:0] w;
    assign busy_n_o = master_mode_i ? !(!chip_sel_n_i && far_sel_i && addr_i == far_addr_i)
        : far_busy_n_i;
    // store on overlap unless held off
    always @(posedge clk_sys_i)
    begin
        w = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
        if (!upper_byte_en_n_i)
            w[15:8] = bus_i[15:8];
        if (!lower_byte_en_n_i)
            w[7:0] = bus_i[7:0];
        if (!rd_wr_n_i && !chip_sel_n_i && busy_n_o)
            mem[addr_i] = w;
        if (!rd_wr_n_i && !flag_select_n_i)
            flags[addr_i[2:0]] = bus_i[0];
        last <= rdata_o;
    end
    always_comb
    begin
        rdata_o = ~last;
        if (rd_wr_n_i && !out_en_n_i && !chip_sel_n_i && busy_n_o)
            rdata_o = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
        if (rd_wr_n_i && !out_en_n_i && !flag_select_n_i)
            rdata_o = {16{flags[addr_i[2:0]]}};
    end
endmodule
`default_nettype wire

// *** tb/sram_port_host_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// Pin-order properties of the port host
module sram_port_host_props (
    input wire logic clk_sys_i, // Clock
    input wire logic nrst_i, // Reset, low
    input wire logic req_valid_i, // Request
    input wire logic req_ready_o, // Taken
    input wire logic req_write_i, // Write
    input wire logic rsp_valid_o, // Done
    input wire logic [14:0] addr_o, // Address
    input wire logic chip_sel_n_o, // Select
    input wire logic rd_wr_n_o, // Direction
    input wire logic out_en_n_o, // Output enable
    input wire logic upper_byte_en_n_o, // Upper lane
    input wire logic lower_byte_en_n_o, // Lower lane
    input wire logic flag_select_n_o, // Flag select
    input wire logic data_oe_o, // Data driven
    input wire logic busy_n_i, // Contention
    input wire logic master_mode_i // Mode
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    // Write steps
    sequence s_take_wr;
        req_valid_i && req_ready_o && req_write_i;
    endsequence
    sequence s_strobe;
        !rd_wr_n_o [*2];
    endsequence
    a_addr_quiet: assert property ($changed(addr_o) |-> rd_wr_n_o && $past(rd_wr_n_o))
        else $error("address moved in write strobe");
    a_drive_off: assert property (data_oe_o |-> out_en_n_o && !rd_wr_n_o)
        else $error("data driven outside write");
    a_sel_late: assert property ($fell(rd_wr_n_o) |-> $past(chip_sel_n_o && flag_select_n_o))
        else $error("select fell before write");
    a_sel_exclusive: assert property (chip_sel_n_o || flag_select_n_o)
        else $error("both selects low");
    a_sem_lanes: assert property (!flag_select_n_o |-> upper_byte_en_n_o && lower_byte_en_n_o)
        else $error("lanes enabled on flag access");
    a_pulse_width: assert property ($fell(rd_wr_n_o) |-> s_strobe)
        else $error("write strobe too short");
    a_write_done: assert property (s_take_wr ##1 busy_n_i [*4] |=> rsp_valid_o)
        else $error("write answer late");
    a_busy_hold: assert property (!master_mode_i && !busy_n_i && !rd_wr_n_o |=> !rd_wr_n_o)
        else $error("strobe released while held off");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0, req_write_i = 1'b0, req_sem_i = 1'b0, req_ready_o, rsp_valid_o;
    logic [14:0] req_addr_i = 15'h0000, addr_o, far_addr = 15'h0000;
    logic [15:0] req_wdata_i = 16'h0000, rsp_rdata_o, data_o, dev_rdata, bus;
    logic [1:0] req_byte_en_i = 2'h3;
    logic rsp_sem_flag_o, rsp_sem_mismatch_o, chip_sel_n_o, rd_wr_n_o, out_en_n_o, data_oe_o;
    logic upper_byte_en_n_o, lower_byte_en_n_o, flag_select_n_o, busy_n;
    logic master_mode = 1'b1, far_sel = 1'b0, far_busy_n = 1'b1;
    logic [31:0] rng = 32'h514b;
    int err_count = 0;
    int samples_checked = 0;
    int ref_mem [int];
    int i;
    assign bus = data_oe_o ? data_o : dev_rdata;
    always #(sram_host_pkg::CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
    sram_port_host i_sram_port_host (.clk_sys_i, .nrst_i, .req_valid_i, .req_ready_o,
        .req_write_i, .req_sem_i, .req_addr_i, .req_wdata_i, .req_byte_en_i, .rsp_valid_o,
        .rsp_rdata_o, .rsp_sem_flag_o, .rsp_sem_mismatch_o, .addr_o, .chip_sel_n_o, .rd_wr_n_o,
        .out_en_n_o, .upper_byte_en_n_o, .lower_byte_en_n_o, .flag_select_n_o, .data_i(bus),
        .data_o, .data_oe_o, .busy_n_i(busy_n), .master_mode_i(master_mode));
    dual_port_ram_model i_dual_port_ram_model (.clk_sys_i, .addr_i(addr_o),
        .chip_sel_n_i(chip_sel_n_o), .rd_wr_n_i(rd_wr_n_o), .out_en_n_i(out_en_n_o),
        .upper_byte_en_n_i(upper_byte_en_n_o), .lower_byte_en_n_i(lower_byte_en_n_o),
        .flag_select_n_i(flag_select_n_o), .bus_i(bus), .master_mode_i(master_mode),
        .far_sel_i(far_sel), .far_addr_i(far_addr), .far_busy_n_i(far_busy_n),
        .rdata_o(dev_rdata), .busy_n_o(busy_n));
    // Next pseudo-random value
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask
    // One request, waits for the answer
    task automatic access(input logic wr, input logic flag_select_n, input logic [14:0] a,
        input logic [15:0] d, input logic [1:0] be);
        int n;
        @(negedge clk_sys_i);
        {req_valid_i, req_write_i, req_sem_i, req_addr_i, req_wdata_i} = {1'b1, wr, flag_select_n, a, d};
        req_byte_en_i = be;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 50)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        cmp_word({15'h0000, rsp_valid_o}, 16'h0001);
        if (wr && !flag_select_n)
            ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] : 0) & ~{{8{be[1]}}, {8{be[0]}}}
                | d & {{8{be[1]}}, {8{be[0]}}};
    endtask
    task automatic check_read(input logic [14:0] a);
        access(1'b0, 1'b0, a, 16'h0000, 2'h3);
        cmp_word(rsp_rdata_o, 16'(ref_mem.exists(a) ? ref_mem[a] : 0));
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        // Random writes and reads, back to back
        for (i = 0; i < 30; i++)
        begin
            rng = xs(rng);
            if (rng[20])
                access(1'b1, 1'b0, 15'(rng[2:0]), rng[31:16], rng[9:8]);
            else
                check_read(15'(rng[2:0]));
        end
        // Flag write then read on every slot
        for (i = 0; i < 8; i++)
        begin
            rng = xs(rng);
            access(1'b1, 1'b1, 15'(i), {15'h0000, rng[5]}, 2'h3);
            access(1'b0, 1'b1, 15'(i), 16'h0000, 2'h3);
            cmp_word({14'h0000, rsp_sem_mismatch_o, rsp_sem_flag_o}, {15'h0000, rng[5]});
        end
        // Other port holds the address during a read
        @(negedge clk_sys_i);
        far_addr = 15'h0003;
        far_sel = 1'b1;
        fork
            check_read(15'h0003);
            begin
                repeat (9) @(negedge clk_sys_i);
                far_sel = 1'b0;
            end
        join
        // Slave: write held off then completed
        @(negedge clk_sys_i);
        master_mode = 1'b0;
        far_busy_n = 1'b0;
        fork
            access(1'b1, 1'b0, 15'h0005, 16'ha5c3, 2'h3);
            begin
                repeat (10) @(negedge clk_sys_i);
                far_busy_n = 1'b1;
            end
        join
        check_read(15'h0005);
        give_verdict();
    end
endmodule
bind sram_port_host sram_port_host_props i_props (.clk_sys_i, .nrst_i, .req_valid_i,
    .req_ready_o, .req_write_i, .rsp_valid_o, .addr_o, .chip_sel_n_o, .rd_wr_n_o, .out_en_n_o,
    .upper_byte_en_n_o, .lower_byte_en_n_o, .flag_select_n_o, .data_oe_o, .busy_n_i,
    .master_mode_i);
`default_nettype wire
